// ---- inc/flash_selfprog_pkg.sv ----
// Constants shared by the flash self-programming sequencer and its helpers.
// Assumes a single 100 MHz system clock and byte-wide CPU registers.
`default_nettype none

package flash_selfprog_pkg;

  // ==========================================================
  // Control and status register fields
  localparam int CTRL_ENABLE_POS = 0;
  localparam int CTRL_ERASE_POS = 1;
  localparam int CTRL_WRITE_POS = 2;
  localparam int CTRL_LOCK_POS = 3;
  localparam int CTRL_REENABLE_POS = 4;
  localparam int CTRL_BUSY_POS = 6;
  localparam int CTRL_INT_EN_POS = 7;
  localparam logic [4:0] CTRL_CMD_RESET = 5'h00;
  localparam logic CTRL_INT_EN_RESET = 1'b0;
  localparam logic CTRL_BUSY_RESET = 1'b0;

  // ==========================================================
  // Command patterns in the low five control bits
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;

  // ==========================================================
  // Address layout
  localparam int PROG_SPACE_KB = 64;
  localparam int EXT_BOUNDARY_KB = 64;
  localparam bit HAS_EXTENSION = PROG_SPACE_KB > EXT_BOUNDARY_KB;
  localparam int ADDR_W = 24;
  localparam int WORD_LSB = 1;
  localparam int WORD_MSB = 5;
  localparam int WORD_W = 5;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_W = 18;
  localparam int PAGE_WORDS = 32;
  localparam logic [PAGE_W-1:0] STALL_FIRST_PAGE = 18'h003c0;
  localparam int LOCK_W = 6;
  localparam logic [7:0] BLOCKED_READ_BYTE = 8'hff;

  // ==========================================================
  // Timing
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint OP_TIME_MIN_NS = 3200000;
  localparam longint OP_TIME_MAX_NS = 3400000;
  localparam int OP_CYCLES = int'((OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int OP_CYCLES_MAX = int'(OP_TIME_MAX_NS / CLK_PERIOD_NS);
  localparam int TIMER_W = 19;

  typedef enum logic [1:0] {OP_IDLE, OP_ERASING, OP_WRITING, OP_LOCKING} op_type;

endpackage : flash_selfprog_pkg

`default_nettype wire

// ---- rtl/flash_self_program_sequencer.sv ----
// Flash self-programming sequencer: control register, arming, erase,
// page write, lock setting, buffer loading and program-memory byte reads.
// Assumes the CPU presents its pointer and data registers as levels and
// store/load instructions as one-cycle pulses on sys_clk.
`default_nettype none

module flash_self_program_sequencer
  import flash_selfprog_pkg::*;
#(
  parameter int OP_CYCLES_P = OP_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control and status register
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // CPU pointer and data registers
  input wire logic [7:0] flash_pointer_low,
  input wire logic [7:0] flash_pointer_high,
  input wire logic [7:0] flash_pointer_extension,
  input wire logic [7:0] data_reg_low,
  input wire logic [7:0] data_reg_high,
  // CPU instruction strobes
  input wire logic store_program_op,
  input wire logic load_program_op,
  output logic [7:0] load_data,
  output logic load_valid,
  output logic cpu_stall,
  output logic selfprog_irq,
  // EEPROM interlock
  input wire logic eeprom_write_active,
  output logic fuse_lock_read_ok,
  // Flash array side
  output logic array_read_req,
  output logic [ADDR_W-2:0] array_read_addr,
  input wire logic [15:0] array_read_word,
  output logic concurrent_read_blocked,
  output logic array_erase_req,
  output logic array_write_req,
  output logic array_lock_req,
  output logic [PAGE_W-1:0] array_page,
  output logic [LOCK_W-1:0] array_lock_mask,
  input wire logic [WORD_W-1:0] array_buf_idx,
  output logic [15:0] array_buf_word
);

  typedef struct packed {
    logic [4:0] cmd;
    logic int_en;
    logic busy;
    op_type op;
    logic [TIMER_W-1:0] timer;
    logic [PAGE_W-1:0] page;
    logic stall_region;
    logic [LOCK_W-1:0] lock_mask;
    logic erase_req;
    logic write_req;
    logic lock_req;
    logic read_req;
    logic [ADDR_W-2:0] read_addr;
    logic read_wait;
    logic read_refused;
    logic read_hi;
    logic [7:0] load_data;
    logic load_valid;
    logic fuse_ok;
  } seq_state_type;

  seq_state_type s_q;
  seq_state_type s_d;

  logic [ADDR_W-1:0] z_addr;
  logic [7:0] ext_eff;
  logic [PAGE_W-1:0] z_page;
  logic ctrl_accept;
  logic arm;
  logic fire;
  logic window_open;
  logic expire;
  logic buf_load;
  logic buf_clear;
  logic buf_any;

  // ==========================================================
  // Address formation
  // extension byte optional
  generate
    if (HAS_EXTENSION)
    begin : g_ext
      assign ext_eff = flash_pointer_extension;
    end
    else
    begin : g_no_ext
      assign ext_eff = 8'h00;
    end
  endgenerate

  assign z_addr = {ext_eff, flash_pointer_high, flash_pointer_low};
  assign z_page = z_addr[ADDR_W-1:PAGE_LSB];

  // ==========================================================
  // Arming
  // refuse during EEPROM write
  assign ctrl_accept = ctrl_wr && !eeprom_write_active && (s_q.op == OP_IDLE);
  assign arm = ctrl_accept && ctrl_wdata[CTRL_ENABLE_POS];
  assign fire = store_program_op && window_open && (s_q.op == OP_IDLE) && !eeprom_write_active;

  selfprog_arm_window u_window (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .arm(arm),
    .fire(fire),
    .window_open(window_open),
    .expire(expire)
  );

  assign buf_load = fire && (s_q.cmd == CMD_LOAD);

  selfprog_page_buffer u_buffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(buf_load),
    .load_idx(z_addr[WORD_MSB:WORD_LSB]),
    .load_word({data_reg_high, data_reg_low}),
    .clear(buf_clear),
    .any_loaded(buf_any),
    .rd_idx(array_buf_idx),
    .rd_word(array_buf_word)
  );

  // ==========================================================
  // Sequencer
  always_comb
  begin
    s_d = s_q;
    buf_clear = 1'b0;
    s_d.erase_req = 1'b0;
    s_d.write_req = 1'b0;
    s_d.lock_req = 1'b0;
    s_d.read_req = 1'b0;
    s_d.read_wait = s_q.read_req;
    s_d.load_valid = 1'b0;
    s_d.fuse_ok = !eeprom_write_active;

    if (ctrl_wr)
    begin
      s_d.int_en = ctrl_wdata[CTRL_INT_EN_POS];
    end
    if (ctrl_accept)
    begin
      s_d.cmd = ctrl_wdata[4:0];
      if (ctrl_wdata[4:0] == CMD_REENABLE)
      begin
        s_d.busy = 1'b0;
        buf_clear = 1'b1;
      end
    end

    if (expire)
    begin
      s_d.cmd = CTRL_CMD_RESET;
    end

    if (fire)
    begin
      case (s_q.cmd)
        CMD_ERASE:
        begin
          s_d.op = OP_ERASING;
          s_d.page = z_page;
          s_d.stall_region = z_page >= STALL_FIRST_PAGE;
          s_d.erase_req = 1'b1;
          s_d.busy = 1'b1;
          s_d.timer = TIMER_W'(OP_CYCLES_P - 1);
        end
        CMD_WRITE:
        begin
          s_d.op = OP_WRITING;
          s_d.page = z_page;
          s_d.stall_region = z_page >= STALL_FIRST_PAGE;
          s_d.write_req = 1'b1;
          s_d.busy = 1'b1;
          s_d.timer = TIMER_W'(OP_CYCLES_P - 1);
        end
        CMD_LOCK:
        begin
          s_d.op = OP_LOCKING;
          s_d.lock_mask = ~data_reg_low[LOCK_W-1:0];
          s_d.lock_req = 1'b1;
          s_d.stall_region = 1'b0;
          s_d.timer = TIMER_W'(OP_CYCLES_P - 1);
        end
        default:
        begin
          s_d.cmd = CTRL_CMD_RESET;
        end
      endcase
    end

    if (s_q.op != OP_IDLE)
    begin
      if (s_q.timer == '0)
      begin
        s_d.op = OP_IDLE;
        s_d.cmd = CTRL_CMD_RESET;
        s_d.stall_region = 1'b0;
        if (s_q.op == OP_WRITING)
        begin
          buf_clear = 1'b1;
        end
      end
      else
      begin
        s_d.timer = s_q.timer - TIMER_W'(1);
      end
    end

    if (eeprom_write_active && buf_any)
    begin
      buf_clear = 1'b1;
    end

    if (load_program_op)
    begin
      s_d.read_addr = z_addr[ADDR_W-1:1];
      s_d.read_hi = z_addr[0];
      s_d.read_refused = s_q.busy && (z_page < STALL_FIRST_PAGE);
      s_d.read_req = 1'b1;
    end
    if (s_q.read_wait)
    begin
      s_d.load_valid = 1'b1;
      if (s_q.read_refused)
      begin
        s_d.load_data = BLOCKED_READ_BYTE;
      end
      else if (s_q.read_hi)
      begin
        s_d.load_data = array_read_word[15:8];
      end
      else
      begin
        s_d.load_data = array_read_word[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.cmd <= CTRL_CMD_RESET;
      s_q.int_en <= CTRL_INT_EN_RESET;
      s_q.busy <= CTRL_BUSY_RESET;
      s_q.op <= OP_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb
  begin
    ctrl_rdata = 8'h00;
    ctrl_rdata[4:0] = s_q.cmd;
    ctrl_rdata[CTRL_BUSY_POS] = s_q.busy;
    ctrl_rdata[CTRL_INT_EN_POS] = s_q.int_en;
  end

  assign selfprog_irq = s_q.int_en && !s_q.cmd[CTRL_ENABLE_POS];

  assign cpu_stall = (s_q.op == OP_ERASING || s_q.op == OP_WRITING) && s_q.stall_region;

  assign concurrent_read_blocked = s_q.busy;

  assign array_read_req = s_q.read_req && !s_q.read_refused;
  assign array_read_addr = s_q.read_addr;
  assign load_data = s_q.load_data;
  assign load_valid = s_q.load_valid;
  assign fuse_lock_read_ok = s_q.fuse_ok;
  assign array_erase_req = s_q.erase_req;
  assign array_write_req = s_q.write_req;
  assign array_lock_req = s_q.lock_req;
  assign array_page = s_q.page;
  assign array_lock_mask = s_q.lock_mask;

endmodule : flash_self_program_sequencer

`default_nettype wire

// ---- rtl/selfprog_arm_window.sv ----
// Four-cycle arming window opened by a control write.
// Assumes arm and fire are one-cycle pulses on sys_clk.
`default_nettype none

module selfprog_arm_window
  import flash_selfprog_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Window control
  input wire logic arm,
  input wire logic fire,
  output logic window_open,
  output logic expire
);

  typedef struct packed {
    logic [2:0] cnt;
  } win_state_type;

  win_state_type s_q;
  win_state_type s_d;

  // ==========================================================
  // Countdown
  always_comb
  begin
    s_d = s_q;
    if (arm)
    begin
      s_d.cnt = ARM_CYCLES;
    end
    else if (fire)
    begin
      s_d.cnt = 3'h0;
    end
    else if (s_q.cnt != 3'h0)
    begin
      s_d.cnt = s_q.cnt - 3'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign window_open = s_q.cnt != 3'h0;
  assign expire = (s_q.cnt == 3'h1) && !fire && !arm;

endmodule : selfprog_arm_window

`default_nettype wire

// ---- rtl/selfprog_page_buffer.sv ----
// Temporary page buffer with per-word loaded flags.
// Assumes the flash array reads it through rd_idx during a page write.
`default_nettype none

module selfprog_page_buffer
  import flash_selfprog_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Loading
  input wire logic load,
  input wire logic [WORD_W-1:0] load_idx,
  input wire logic [15:0] load_word,
  input wire logic clear,
  output logic any_loaded,
  // Array side read port
  input wire logic [WORD_W-1:0] rd_idx,
  output logic [15:0] rd_word
);

  typedef struct packed {
    logic [PAGE_WORDS-1:0][15:0] mem;
    logic [PAGE_WORDS-1:0] loaded;
    logic [15:0] rd_word;
  } buf_state_type;

  buf_state_type s_q;
  buf_state_type s_d;

  // ==========================================================
  // Storage
  always_comb
  begin
    s_d = s_q;
    s_d.rd_word = s_q.mem[rd_idx];
    if (clear)
    begin
      s_d.loaded = '0;
      s_d.mem = '0;
    end
    // one load per slot
    // A load in the clearing cycle wins
    if (load && (clear || !s_q.loaded[load_idx]))
    begin
      s_d.mem[load_idx] = load_word;
      s_d.loaded[load_idx] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign any_loaded = |s_q.loaded;
  assign rd_word = s_q.rd_word;

endmodule : selfprog_page_buffer

`default_nettype wire

// ---- verif/flash_array_model.sv ----
// Flash array model: answers word reads and drains the page buffer.
// Assumes read words hold two cycles and buffer words lag the index.
`default_nettype none

module flash_array_model
  import flash_selfprog_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Read port
  input wire logic array_read_req,
  input wire logic [ADDR_W-2:0] array_read_addr,
  output logic [15:0] array_read_word,
  // Page write
  input wire logic array_write_req,
  output logic [WORD_W-1:0] array_buf_idx,
  input wire logic [15:0] array_buf_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_q;
  logic on_q;
  logic [5:0] n_q;
  logic [15:0] junk_q;
  logic [15:0] page_q [PAGE_WORDS];
  // Junk outside the answer window keeps stale data from matching
  assign array_read_word = (array_read_req || rd_q)
    ? {array_read_addr[7:0] ^ 8'h5a, array_read_addr[7:0]} : junk_q;
  assign array_buf_idx = n_q[4:0];
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
      on_q <= 1'b0;
      n_q <= 6'h20;
      junk_q <= 16'h5555;
    end
    else
    begin
      rd_q <= array_read_req;
      junk_q <= ~array_read_word;
      if (array_write_req)
      begin
        on_q <= 1'b1;
        n_q <= 6'h00;
      end
      else if (on_q)
      begin
        n_q <= n_q + 6'h01;
        on_q <= n_q != 6'h20;
        if (n_q != 6'h00)
          page_q[n_q[4:0] - 5'h01] <= array_buf_word;
      end
    end
  end
endmodule : flash_array_model

`default_nettype wire

// ---- verif/flash_selfprog_sva.sv ----
// Checker for the flash self-programming sequencer top-level ports.
// Assumes binding into the sequencer, one clock, synchronous reset.
`default_nettype none

module flash_selfprog_sva
  import flash_selfprog_pkg::*;
#(
  parameter int OP_CYCLES_P = OP_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control and CPU side
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] data_reg_low,
  input wire logic store_program_op,
  input wire logic cpu_stall,
  input wire logic selfprog_irq,
  input wire logic eeprom_write_active,
  input wire logic fuse_lock_read_ok,
  // Array side
  input wire logic concurrent_read_blocked,
  input wire logic array_erase_req,
  input wire logic array_write_req,
  input wire logic array_lock_req,
  input wire logic [PAGE_W-1:0] array_page,
  input wire logic [LOCK_W-1:0] array_lock_mask
);
  localparam logic [TIMER_W-1:0] OP_LEN = TIMER_W'(OP_CYCLES_P);
  logic [5:0] lock_data;
  logic op_req;
  logic [TIMER_W-1:0] op_cnt_q;
  assign lock_data = data_reg_low[5:0];
  assign op_req = array_erase_req || array_write_req || array_lock_req;

  // Counts the cycles an operation holds the enable bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      op_cnt_q <= '0;
    end
    else if (op_req)
    begin
      op_cnt_q <= TIMER_W'(1);
    end
    else if (op_cnt_q != '0 && ctrl_rdata[0])
    begin
      op_cnt_q <= op_cnt_q + TIMER_W'(1);
    end
    else
    begin
      op_cnt_q <= '0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Arming window
  sequence s_arm;
    ctrl_wr && ctrl_wdata[4:0] == CMD_LOAD && !eeprom_write_active && !ctrl_rdata[0];
  endsequence
  sequence s_quiet;
    (!store_program_op && !ctrl_wr) [*4];
  endsequence
  property p_expire;
    s_arm ##1 s_quiet |=> ctrl_rdata[4:0] == 5'h00;
  endproperty
  a_expire: assert property (p_expire) else $error("window did not expire");

  // ==========================================================
  // Operations
  property p_dur;
    op_cnt_q != '0 |-> (ctrl_rdata[0] ? op_cnt_q < OP_LEN : op_cnt_q == OP_LEN);
  endproperty
  a_dur: assert property (p_dur) else $error("operation length wrong");
  property p_busy;
    (array_erase_req || array_write_req) |-> ctrl_rdata[6] && concurrent_read_blocked;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");
  property p_blk;
    concurrent_read_blocked == ctrl_rdata[6];
  endproperty
  a_blk: assert property (p_blk) else $error("blocked differs from busy");
  property p_stall_pg;
    (array_erase_req || array_write_req) |-> cpu_stall == (array_page >= STALL_FIRST_PAGE);
  endproperty
  a_stall_pg: assert property (p_stall_pg) else $error("stall region wrong");
  property p_stall;
    cpu_stall |-> ctrl_rdata[0] && ctrl_rdata[6];
  endproperty
  a_stall: assert property (p_stall) else $error("stall outside operation");
  property p_lock;
    array_lock_req |-> !cpu_stall && (array_lock_mask ^ $past(lock_data)) == 6'h3f;
  endproperty
  a_lock: assert property (p_lock) else $error("lock mask or stall wrong");
  property p_irq;
    selfprog_irq == (ctrl_rdata[7] && !ctrl_rdata[0]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  property p_reen;
    ctrl_wr && ctrl_wdata[4:0] == CMD_REENABLE && !ctrl_rdata[0] && !eeprom_write_active
      |=> !ctrl_rdata[6];
  endproperty
  a_reen: assert property (p_reen) else $error("busy not cleared");

  // ==========================================================
  // EEPROM interlock
  property p_eep;
    eeprom_write_active |=> !fuse_lock_read_ok;
  endproperty
  a_eep: assert property (p_eep) else $error("fuse read not blocked");
  property p_eep_cmd;
    ctrl_wr && eeprom_write_active && !ctrl_rdata[0] |=> ctrl_rdata[4:0] == 5'h00;
  endproperty
  a_eep_cmd: assert property (p_eep_cmd) else $error("command taken in EEPROM write");
endmodule : flash_selfprog_sva

`default_nettype wire

// ---- verif/tb_flash_self_program_sequencer.sv ----
// Testbench for the flash self-programming sequencer.
// Assumes the array model drains the buffer within the shortened operation.
`default_nettype none

module tb_flash_self_program_sequencer
  import flash_selfprog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPC = 40;
  logic sys_clk, rst_n, ctrl_wr, store_program_op, load_program_op, eeprom_write_active;
  logic [7:0] ctrl_wdata, flash_pointer_low, flash_pointer_high, flash_pointer_extension;
  logic [7:0] data_reg_low, data_reg_high, ctrl_rdata, load_data;
  logic load_valid, cpu_stall, selfprog_irq, fuse_lock_read_ok, array_read_req;
  logic concurrent_read_blocked, array_erase_req, array_write_req, array_lock_req;
  logic [ADDR_W-2:0] array_read_addr;
  logic [15:0] array_read_word, array_buf_word;
  logic [PAGE_W-1:0] array_page;
  logic [LOCK_W-1:0] array_lock_mask;
  logic [WORD_W-1:0] array_buf_idx;
  int fails, comparisons;

  flash_self_program_sequencer #(.OP_CYCLES_P(OPC)) i_flash_self_program_sequencer (
    .sys_clk, .rst_n, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .flash_pointer_low,
    .flash_pointer_high, .flash_pointer_extension, .data_reg_low, .data_reg_high,
    .store_program_op, .load_program_op, .load_data, .load_valid, .cpu_stall,
    .selfprog_irq, .eeprom_write_active, .fuse_lock_read_ok, .array_read_req,
    .array_read_addr, .array_read_word, .concurrent_read_blocked, .array_erase_req,
    .array_write_req, .array_lock_req, .array_page, .array_lock_mask, .array_buf_idx,
    .array_buf_word);
  flash_array_model i_flash_array_model (.sys_clk, .rst_n, .array_read_req,
    .array_read_addr, .array_read_word, .array_write_req, .array_buf_idx, .array_buf_word);

  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic ctrl(input logic [7:0] v);
    ctrl_wr = 1'b1;
    ctrl_wdata = v;
    cyc(1);
    ctrl_wr = 1'b0;
  endtask : ctrl
  task automatic op(input logic [7:0] cmd, input logic [15:0] p);
    {flash_pointer_high, flash_pointer_low} = p;
    ctrl(cmd);
    store_program_op = 1'b1;
    cyc(1);
    store_program_op = 1'b0;
  endtask : op
  task automatic ld(input int i);
    data_reg_high = 8'(i);
    data_reg_low = ~8'(i);
    op(8'h01, 16'h0400 | 16'(i << 1));
  endtask : ld
  task automatic rd(input logic [15:0] p, input logic [7:0] e);
    {flash_pointer_high, flash_pointer_low} = p;
    load_program_op = 1'b1;
    cyc(1);
    load_program_op = 1'b0;
    cyc(2);
    chk("load_valid", 24'h1, load_valid);
    chk("load_data", e, load_data);
  endtask : rd
  task automatic fin;
    for (int k = 0; k < OPC + 4 && ctrl_rdata[0] !== 1'b0; k++)
      cyc(1);
    chk("enable", 24'h0, ctrl_rdata[0]);
  endtask : fin
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // Clock, watchdog and tests
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #100us;
    fails++;
    test_done;
  end
  initial
  begin
    {ctrl_wr, store_program_op, load_program_op, eeprom_write_active} = 4'h0;
    {ctrl_wdata, flash_pointer_low, flash_pointer_high} = 24'h0;
    {flash_pointer_extension, data_reg_low, data_reg_high} = 24'h0;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk("ctrl_reset", 24'h0, ctrl_rdata);
    ctrl(8'h01);
    cyc(5);
    chk("expire", 24'h0, ctrl_rdata[4:0]);
    data_reg_high = 8'hab;
    data_reg_low = 8'hcd;
    op(8'h01, 16'h0400);
    eeprom_write_active = 1'b1;
    cyc(1);
    chk("fuse_ok", 24'h0, fuse_lock_read_ok);
    ctrl(8'h03);
    cyc(1);
    chk("refused", 24'h0, ctrl_rdata);
    eeprom_write_active = 1'b0;
    for (int i = 31; i >= 0; i--)
      ld(i);
    op(8'h03, 16'h043e);
    chk("erase_req", 24'h1, array_erase_req);
    chk("erase_page", 24'h10, array_page);
    chk("busy", 24'h1, ctrl_rdata[6]);
    chk("no_stall", 24'h0, cpu_stall);
    rd(16'h0002, BLOCKED_READ_BYTE);
    chk("latched", 24'h10, array_page);
    fin();
    op(8'h05, 16'h0400);
    chk("write_req", 24'h1, array_write_req);
    fin();
    for (int i = 0; i < 32; i++)
      chk("page_word", {8'(i), ~8'(i)}, i_flash_array_model.page_q[i]);
    ctrl(8'h11);
    cyc(1);
    chk("reenable", 24'h0, ctrl_rdata[6]);
    cyc(5);
    rd(16'h0086, 8'h43);
    rd(16'h0087, 8'h19);
    data_reg_low = 8'hf0;
    op(8'h09, 16'h1234);
    chk("lock_req", 24'h1, array_lock_req);
    chk("lock_mask", 24'h0f, array_lock_mask);
    chk("lock_stall", 24'h0, cpu_stall | ctrl_rdata[6]);
    fin();
    ctrl(8'h80);
    cyc(1);
    chk("irq_on", 24'h1, selfprog_irq);
    op(8'h83, 16'hf000);
    chk("stall", 24'h1, cpu_stall);
    chk("irq_off", 24'h0, selfprog_irq);
    fin();
    chk("irq_back", 24'h1, selfprog_irq);
    // A reset mid-run must free slot 5 for a new word
    data_reg_high = 8'h12;
    data_reg_low = 8'h34;
    op(8'h01, 16'h040a);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    ld(5);
    op(8'h05, 16'h0400);
    fin();
    chk("reset_clear", 24'h05fa, i_flash_array_model.page_q[5]);
    test_done;
  end
endmodule : tb_flash_self_program_sequencer

bind flash_self_program_sequencer flash_selfprog_sva #(.OP_CYCLES_P(OP_CYCLES_P))
  i_flash_selfprog_sva (.sys_clk, .rst_n, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .data_reg_low,
  .store_program_op, .cpu_stall, .selfprog_irq, .eeprom_write_active, .fuse_lock_read_ok,
  .concurrent_read_blocked, .array_erase_req, .array_write_req, .array_lock_req,
  .array_page, .array_lock_mask);

`default_nettype wire
